// ### hdl/sio_cond.sv
// Safety I/O signal conditioning: standard, tristate and switched inputs, tested outputs,
// inverse output, fieldbus bit mappings, per-input inversion and edge filtering.
// Assumes pins are asynchronous to mclk and a single Avalon-MM master on the register port.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM slave port.
`timescale 1ns/1ps

module sio_cond #(
  parameter int unsigned BOOST_CYC  = sio_pkg::BOOST_CYCLES,
  parameter int unsigned SAMPLE_PER = sio_pkg::SAMPLE_PERIOD
) (
  input  wire logic                 mclk,
  input  wire logic                 nrst,
  input  wire sio_pkg::sio_av_req_s av_req,
  output sio_pkg::sio_av_rsp_s      av_rsp,
  input  wire logic [9:0]           pin_in,
  input  wire logic [1:0]           tri_probe_in,
  output logic [3:0]                io_drive_en,
  output logic                      inv_pull_en,
  output logic [1:0]                tri_test_drive,
  output logic [9:0]                contact_cleaning_boost,
  input  wire logic [2:0]           fb_a_master_bits,
  input  wire logic [1:0]           fb_a_param_bits,
  input  wire logic [15:0]          safe_cyclic_out,
  output logic [15:0]               safe_cyclic_in,
  output logic                      safety_out_off,
  output logic [9:0]                filtered_logical_input,
  output logic [9:0]                logical_input
);

  localparam int NI = sio_pkg::N_IN;

  typedef struct packed {
    logic [31:0]              ctrl;
    logic [7:0]               iocfg;
    logic                     inv_as_out;
    logic                     cfg_reject;
    logic [NI-1:0]            invert;
    logic [NI-1:0]            filt_sel;
    logic [15:0]              rise_dly;
    logic [15:0]              fall_dly;
    logic [4:0]               out_cmd;
    logic [15:0]              cyc_in_cmd;
    logic [NI-1:0]            sync1;
    logic [NI-1:0]            sync2;
    logic [1:0]               probe1;
    logic [1:0]               probe2;
    logic [NI-1:0]            phys;
    logic [3:0]               tri_state;
    logic [NI-1:0]            linv;
    logic [NI-1:0]            lfilt;
    logic [NI-1:0][15:0]      fcnt;
    logic [NI-1:0][22:0]      bcnt;
    logic [NI-1:0]            boost;
    logic [13:0]              scnt;
    logic [3:0]               drive;
    logic [3:0]               drive_d1;
    logic [3:0]               drive_d2;
    logic                     inv_pull;
    logic [1:0]               tri_drv;
    logic                     fault;
    logic [15:0]              cyc_in;
    logic [31:0]              rdata;
    logic                     ack;
  } sio_state_s;

  sio_state_s st_reg;
  sio_state_s st_next;

  // ==========================================================================
  // Combinational next state
  always_comb begin
    logic [1:0]    var_sel;
    logic          tri_test;
    logic          release_win;
    logic          probe_win;
    logic [3:0]    want;
    logic [NI-1:0] raw;
    logic          hit;
    logic [1:0]    mode;
    st_next = st_reg;
    tri_test    = 1'b0;
    release_win = 1'b0;
    probe_win   = 1'b0;
    want        = 4'h0;
    raw         = '0;
    mode        = 2'h0;
    var_sel = st_reg.ctrl[sio_pkg::CTRL_VAR_LSB +: 2];
    hit = av_req.write && !st_reg.ack;

    // ==========================================================================
    // Register writes
    if (hit) begin
      unique case (av_req.address)
        sio_pkg::ADDR_CTRL: begin
          st_next.ctrl = av_req.writedata;
          st_next.ctrl[sio_pkg::CTRL_FAULT_CLR] = 1'b0;
        end
        sio_pkg::ADDR_IOCFG: begin
          // Inverse I/O may not be input and output together
          if (av_req.writedata[9:8] == 2'(sio_pkg::SIO_IO_BOTH) ||
              av_req.writedata[9:8] == 2'(sio_pkg::SIO_IO_BAD)) begin
            st_next.cfg_reject = 1'b1;
          end else begin
            st_next.inv_as_out = (av_req.writedata[9:8] == 2'(sio_pkg::SIO_IO_OUTPUT));
            st_next.cfg_reject = 1'b0;
          end
          st_next.iocfg = av_req.writedata[7:0];
        end
        sio_pkg::ADDR_INVERT:  st_next.invert = av_req.writedata[NI-1:0];
        sio_pkg::ADDR_FILTSEL: st_next.filt_sel = av_req.writedata[NI-1:0];
        sio_pkg::ADDR_RISEDLY: st_next.rise_dly = av_req.writedata[15:0];
        sio_pkg::ADDR_FALLDLY: st_next.fall_dly = av_req.writedata[15:0];
        sio_pkg::ADDR_OUTCMD:  st_next.out_cmd = av_req.writedata[4:0];
        sio_pkg::ADDR_CYCIN:   st_next.cyc_in_cmd = av_req.writedata[15:0];
        default: ;
      endcase
    end

    // ==========================================================================
    // Bus answer: one wait cycle, then ack with data
    st_next.ack = (av_req.read || av_req.write) && !st_reg.ack;
    st_next.rdata = 32'h0000_0000;
    if (av_req.read && !st_reg.ack) begin
      unique case (av_req.address)
        sio_pkg::ADDR_CTRL:    st_next.rdata = st_reg.ctrl;
        sio_pkg::ADDR_IOCFG:   st_next.rdata = {22'h0, st_reg.cfg_reject,
                                                st_reg.inv_as_out, st_reg.iocfg};
        sio_pkg::ADDR_INVERT:  st_next.rdata = {22'h0, st_reg.invert};
        sio_pkg::ADDR_FILTSEL: st_next.rdata = {22'h0, st_reg.filt_sel};
        sio_pkg::ADDR_RISEDLY: st_next.rdata = {16'h0, st_reg.rise_dly};
        sio_pkg::ADDR_FALLDLY: st_next.rdata = {16'h0, st_reg.fall_dly};
        sio_pkg::ADDR_OUTCMD:  st_next.rdata = {27'h0, st_reg.out_cmd};
        sio_pkg::ADDR_STATUS:  st_next.rdata = {23'h0, st_reg.fault, st_reg.tri_state,
                                                st_reg.drive};
        sio_pkg::ADDR_LOGICAL: st_next.rdata = {6'h0, st_reg.lfilt, 6'h0, st_reg.linv};
        sio_pkg::ADDR_CYCOUT:  st_next.rdata = {16'h0, safe_cyclic_out};
        sio_pkg::ADDR_CYCIN:   st_next.rdata = {16'h0, st_reg.cyc_in};
        default:               st_next.rdata = 32'h0000_0000;
      endcase
    end

    // ==========================================================================
    // Pin synchronisers and sampling
    st_next.sync1  = pin_in;
    st_next.sync2  = st_reg.sync1;
    st_next.probe1 = tri_probe_in;
    st_next.probe2 = st_reg.probe1;
    st_next.scnt = (st_reg.scnt >= 14'(SAMPLE_PER - 1)) ? 14'h0 : st_reg.scnt + 14'h1;
    release_win = (st_reg.scnt < 14'(sio_pkg::RELEASE_CYCLES));
    probe_win = (st_reg.scnt >= 14'(sio_pkg::RELEASE_CYCLES + 4)) &&
                (st_reg.scnt < 14'(sio_pkg::RELEASE_CYCLES + 4 + sio_pkg::TEST_CYCLES));

    // Open pins are pulled to ground, so a floating line already arrives as zero
    raw = st_reg.sync2;
    // Combined I/O with its output commanded on: sensor seen only during drive release, after sync latency
    for (int k = 0; k < sio_pkg::N_IO; k++) begin
      int p;
      p = (k == 0) ? sio_pkg::IX_L2 : (k == 1) ? sio_pkg::IX_L5 :
          (k == 2) ? sio_pkg::IX_M3 : sio_pkg::IX_M4;
      mode = st_reg.iocfg[2*k +: 2];
      if (mode == 2'(sio_pkg::SIO_IO_BOTH) && st_reg.out_cmd[k]) begin
        if (st_reg.scnt == 14'(sio_pkg::RELEASE_CYCLES + 1))
          st_next.phys[p] = raw[p];
      end else begin
        st_next.phys[p] = raw[p];
      end
    end
    st_next.phys[0]             = raw[0];
    st_next.phys[sio_pkg::IX_L3] = raw[sio_pkg::IX_L3];
    st_next.phys[sio_pkg::IX_L4] = raw[sio_pkg::IX_L4];
    st_next.phys[sio_pkg::IX_M1] = raw[sio_pkg::IX_M1];
    st_next.phys[sio_pkg::IX_M2] = raw[sio_pkg::IX_M2];
    st_next.phys[sio_pkg::IX_M5] = raw[sio_pkg::IX_M5];
    if (var_sel == 2'(sio_pkg::SIO_VAR_ASI)) begin
      st_next.phys[sio_pkg::IX_M1] = fb_a_master_bits[0];
      st_next.phys[sio_pkg::IX_M2] = fb_a_master_bits[1];
      st_next.phys[sio_pkg::IX_M5] = fb_a_master_bits[2];
    end

    // ==========================================================================
    // Tristate test: drive a probe current, a line that follows it is open
    tri_test = st_reg.ctrl[sio_pkg::CTRL_TRI_TEST_EN] ||
               st_reg.ctrl[sio_pkg::CTRL_TRI_FORCE];
    st_next.tri_drv = (tri_test && probe_win) ? 2'b11 : 2'b00;
    for (int t = 0; t < 2; t++) begin
      int p;
      p = (t == 0) ? sio_pkg::IX_L3 : sio_pkg::IX_L4;
      if (!tri_test) begin
        st_next.tri_state[2*t +: 2] = raw[p] ? 2'(sio_pkg::SIO_TRI_HIGH)
                                             : 2'(sio_pkg::SIO_TRI_LOW);
      end else if (st_reg.scnt == 14'(sio_pkg::RELEASE_CYCLES + 4 + sio_pkg::TEST_CYCLES)) begin
        // A line that follows the probe is open, even though its level then reads high
        st_next.tri_state[2*t +: 2] = st_reg.probe2[t] ? 2'(sio_pkg::SIO_TRI_OPEN) :
                                      raw[p]           ? 2'(sio_pkg::SIO_TRI_HIGH) :
                                                         2'(sio_pkg::SIO_TRI_LOW);
      end
    end

    // ==========================================================================
    // Outputs
    for (int k = 0; k < sio_pkg::N_IO; k++) begin
      mode = st_reg.iocfg[2*k +: 2];
      want[k] = st_reg.out_cmd[k] &&
                (mode == 2'(sio_pkg::SIO_IO_OUTPUT) || mode == 2'(sio_pkg::SIO_IO_BOTH));
      st_next.drive[k] = want[k] && !(mode == 2'(sio_pkg::SIO_IO_BOTH) && release_win);
    end
    if (var_sel == 2'(sio_pkg::SIO_VAR_ASI)) begin
      st_next.drive[2] = !fb_a_param_bits[0];
      st_next.drive[3] = !fb_a_param_bits[1];
    end
    st_next.inv_pull = st_reg.inv_as_out && st_reg.out_cmd[4] &&
                       var_sel != 2'(sio_pkg::SIO_VAR_ASI);

    // Read-back check on tested outputs outside the release window
    // Pin readback lags the drive by the two synchroniser flops
    st_next.drive_d1 = st_reg.drive;
    st_next.drive_d2 = st_reg.drive_d1;
    if (hit && av_req.address == sio_pkg::ADDR_CTRL &&
        av_req.writedata[sio_pkg::CTRL_FAULT_CLR])
      st_next.fault = 1'b0;
    for (int k = 0; k < sio_pkg::N_IO; k++) begin
      int p;
      p = (k == 0) ? sio_pkg::IX_L2 : (k == 1) ? sio_pkg::IX_L5 :
          (k == 2) ? sio_pkg::IX_M3 : sio_pkg::IX_M4;
      mode = st_reg.iocfg[2*k +: 2];
      if (mode == 2'(sio_pkg::SIO_IO_OUTPUT) && st_reg.scnt > 14'(sio_pkg::RELEASE_CYCLES + 3) &&
          raw[p] != st_reg.drive_d2[k] &&
          !(var_sel == 2'(sio_pkg::SIO_VAR_ASI) && k >= 2))
        st_next.fault = 1'b1;
    end

    // ==========================================================================
    // Inversion, edge filter, contact cleaning
    for (int i = 0; i < NI; i++) begin
      st_next.linv[i] = st_reg.phys[i] ^ st_reg.invert[i];
      if (!st_reg.filt_sel[i]) begin
        st_next.lfilt[i] = st_reg.linv[i];
        st_next.fcnt[i] = 16'h0;
      end else if (st_reg.linv[i] == st_reg.lfilt[i]) begin
        st_next.fcnt[i] = 16'h0;
      end else if (st_reg.fcnt[i] >= (st_reg.linv[i] ? st_reg.rise_dly : st_reg.fall_dly)) begin
        st_next.lfilt[i] = st_reg.linv[i];
        st_next.fcnt[i] = 16'h0;
      end else begin
        st_next.fcnt[i] = st_reg.fcnt[i] + 16'h1;
      end
      // No boost circuit on the inverse line
      if (st_reg.phys[i] && !st_reg.sync2[i] && st_reg.sync1[i] && i != sio_pkg::IX_M5) begin
        st_next.bcnt[i] = 23'(BOOST_CYC);
      end else if (st_reg.bcnt[i] != 23'h0) begin
        st_next.bcnt[i] = st_reg.bcnt[i] - 23'h1;
      end
      if (!st_reg.sync2[i] && st_reg.sync1[i] && i != sio_pkg::IX_M5)
        st_next.bcnt[i] = 23'(BOOST_CYC);
      st_next.boost[i] = (st_next.bcnt[i] != 23'h0);
    end

    // Cyclic bus bits pass through, registered, in the safe-bus variant only; zero otherwise
    st_next.cyc_in = (var_sel == 2'(sio_pkg::SIO_VAR_SAFEBUS)) ? st_reg.cyc_in_cmd
                                                                : 16'h0000;
  end

  // ==========================================================================
  // State register
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      st_reg       <= '0;
      st_reg.ctrl  <= sio_pkg::CTRL_RST;
      st_reg.iocfg <= sio_pkg::IOCFG_RST[7:0];
      st_reg.rise_dly <= sio_pkg::DLY_RST;
      st_reg.fall_dly <= sio_pkg::DLY_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // Sources for functions: cyclic bits stand beside the aux lines, unfiltered
  always_comb begin
    av_rsp.readdata    = st_reg.rdata;
    av_rsp.waitrequest = !st_reg.ack;
  end
  assign io_drive_en            = st_reg.drive;
  assign inv_pull_en            = st_reg.inv_pull;
  assign tri_test_drive         = st_reg.tri_drv;
  assign contact_cleaning_boost = st_reg.boost;
  assign safe_cyclic_in         = st_reg.cyc_in;
  assign safety_out_off         = st_reg.fault;
  assign filtered_logical_input = st_reg.lfilt;
  assign logical_input          = st_reg.linv;

endmodule

// ### pkg/sio_pkg.sv
// Package for the safety I/O signal conditioning block: offsets, fields, timing, carriers.
// Assumes a 10 MHz device clock and an Avalon-MM register master with waitrequest.
package sio_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ          = 10000000;
  localparam int unsigned BOOST_MS        = 100;
  localparam int unsigned BOOST_CYCLES    = BOOST_MS * (CLK_HZ / 1000);
  localparam int unsigned RELEASE_NS      = 2000;
  localparam int unsigned RELEASE_CYCLES  = (RELEASE_NS * (CLK_HZ / 1000000) + 999) / 1000;
  localparam int unsigned SAMPLE_PERIOD   = 10000;
  localparam int unsigned TEST_NS         = 1000;
  localparam int unsigned TEST_CYCLES     = (TEST_NS * (CLK_HZ / 1000000) + 999) / 1000;

  // ==========================================================================
  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_IOCFG    = 8'h04;
  localparam logic [7:0] ADDR_INVERT   = 8'h08;
  localparam logic [7:0] ADDR_FILTSEL  = 8'h0c;
  localparam logic [7:0] ADDR_RISEDLY  = 8'h10;
  localparam logic [7:0] ADDR_FALLDLY  = 8'h14;
  localparam logic [7:0] ADDR_OUTCMD   = 8'h18;
  localparam logic [7:0] ADDR_STATUS   = 8'h1c;
  localparam logic [7:0] ADDR_LOGICAL  = 8'h20;
  localparam logic [7:0] ADDR_CYCOUT   = 8'h24;
  localparam logic [7:0] ADDR_CYCIN    = 8'h28;

  // CTRL fields
  localparam int CTRL_TRI_TEST_EN  = 0;
  localparam int CTRL_TRI_FORCE    = 1;
  localparam int CTRL_VAR_LSB      = 2;
  localparam int CTRL_FAULT_CLR    = 4;
  localparam int CTRL_MUTING_PKG   = 5;

  // Reset values
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam logic [31:0] IOCFG_RST   = 32'h0000_0000;
  localparam logic [15:0] DLY_RST     = 16'h0000;

  // Physical input indices: L1 L2 L3 L4 L5 M1 M2 M3 M4 M5
  localparam int N_IN = 10;
  localparam int IX_L2 = 1;
  localparam int IX_L3 = 2;
  localparam int IX_L4 = 3;
  localparam int IX_L5 = 4;
  localparam int IX_M1 = 5;
  localparam int IX_M2 = 6;
  localparam int IX_M3 = 7;
  localparam int IX_M4 = 8;
  localparam int IX_M5 = 9;
  localparam int N_IO = 4;  // L2 L5 M3 M4

  typedef enum logic [1:0] {SIO_VAR_WIRED, SIO_VAR_ASI, SIO_VAR_SAFEBUS, SIO_VAR_RSV} sio_var_e;
  typedef enum logic [1:0] {SIO_IO_INPUT, SIO_IO_OUTPUT, SIO_IO_BOTH, SIO_IO_BAD} sio_iocfg_e;
  typedef enum logic [1:0] {SIO_TRI_LOW, SIO_TRI_HIGH, SIO_TRI_OPEN, SIO_TRI_UNK} sio_tri_e;

  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } sio_av_req_s;

  typedef struct packed {
    logic [31:0] readdata;
    logic        waitrequest;
  } sio_av_rsp_s;

endpackage

// ### tb/sio_field.sv
// Far-side model: field sensors, loads with pull-downs, and open tristate lines.
// Assumes levels settle at once; the design's own input flops take care of timing.
`timescale 1ns/1ps
module sio_field (
  input  wire logic [3:0] io_drive_en,
  input  wire logic       inv_pull_en,
  input  wire logic [1:0] tri_test_drive,
  input  wire logic [9:0] sensor,
  input  wire logic [1:0] open_line,
  input  wire logic [3:0] stuck_low,
  output logic      [9:0] pin_in,
  output logic      [1:0] tri_probe_in
);
  logic [3:0] drv;
  // A stuck switch models a broken load path, so readback can disagree
  assign drv = io_drive_en & ~stuck_low;
  always_comb begin
    // Pull-downs: an undriven line and an open sensor read as ground
    pin_in    = sensor;
    pin_in[1] = sensor[1] | drv[0];
    pin_in[4] = sensor[4] | drv[1];
    pin_in[7] = sensor[7] | drv[2];
    pin_in[8] = sensor[8] | drv[3];
    pin_in[9] = sensor[9] & ~inv_pull_en;
    // An open tristate line just follows the probe drive
    pin_in[2] = open_line[0] ? tri_test_drive[0] : sensor[2];
    pin_in[3] = open_line[1] ? tri_test_drive[1] : sensor[3];
    tri_probe_in = open_line & tri_test_drive;
  end
endmodule

// ### tb/sio_cond_properties.sv
// Checker on the ports of the conditioning block.
// Assumes one register request at a time, released after its accepting edge.
`timescale 1ns/1ps
module sio_cond_properties #(
  parameter int unsigned BOOST_CYC  = 50,
  parameter int unsigned SAMPLE_PER = 64
) (
  input wire logic                 mclk,
  input wire logic                 nrst,
  input wire sio_pkg::sio_av_req_s av_req,
  input wire sio_pkg::sio_av_rsp_s av_rsp,
  input wire logic [3:0]           io_drive_en,
  input wire logic                 inv_pull_en,
  input wire logic                 safety_out_off,
  input wire logic [9:0]           contact_cleaning_boost,
  input wire logic [9:0]           filtered_logical_input,
  input wire logic [9:0]           logical_input
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  logic        req;
  logic        clr;
  logic [31:0] bcnt;
  assign req = av_req.read | av_req.write;
  assign clr = av_req.write & (av_req.address == 8'h00) & av_req.writedata[4];
  always_ff @(posedge mclk) begin
    bcnt <= (!nrst || !contact_cleaning_boost[0]) ? 32'h0 : bcnt + 32'h1;
  end
  sequence s_ack;
    !av_rsp.waitrequest ##1 av_rsp.waitrequest;
  endsequence
  sequence s_unmapped_read;
    $rose(av_req.read) && (av_req.address >= 8'h2c);
  endsequence
  a_reset_idle: assert property (disable iff (1'b0) !nrst |=> av_rsp.waitrequest
    && !safety_out_off && io_drive_en == 4'h0 && !inv_pull_en) else $error("reset idle");
  a_ack_timing: assert property ($rose(req) |=> s_ack) else $error("ack timing");
  a_ack_cause: assert property (!av_rsp.waitrequest |-> req && $past(req))
    else $error("ack without request");
  a_unmapped_zero: assert property (s_unmapped_read |=> av_rsp.readdata == 32'h0)
    else $error("unmapped read not zero");
  a_fault_sticky: assert property (safety_out_off && !clr && !$past(clr) |=> safety_out_off)
    else $error("fault dropped without clear");
  a_boost_bound: assert property (bcnt <= BOOST_CYC + 4)
    else $error("boost too long");
  a_boost_min: assert property ($fell(contact_cleaning_boost[0]) |-> $past(bcnt) >= BOOST_CYC - 2)
    else $error("boost too short");
  a_filt_rise: assert property ((filtered_logical_input & ~$past(filtered_logical_input)
    & ~$past(logical_input)) == 10'h0) else $error("filtered rose ahead of logical");
  a_filt_fall: assert property ((~filtered_logical_input & $past(filtered_logical_input)
    & $past(logical_input)) == 10'h0) else $error("filtered fell ahead of logical");
endmodule

bind sio_cond sio_cond_properties #(.BOOST_CYC(BOOST_CYC), .SAMPLE_PER(SAMPLE_PER)) chk_u (
  .mclk(mclk), .nrst(nrst), .av_req(av_req), .av_rsp(av_rsp), .io_drive_en(io_drive_en),
  .inv_pull_en(inv_pull_en), .safety_out_off(safety_out_off),
  .contact_cleaning_boost(contact_cleaning_boost),
  .filtered_logical_input(filtered_logical_input), .logical_input(logical_input));

// ### tb/sio_cond_tb.sv
// Self-checking bench for the conditioning block with the field model on its pins.
// Assumes shortened boost and sample period so the run stays short.
`timescale 1ns/1ps
module sio_cond_tb;
  localparam int unsigned BC = 50;
  localparam int unsigned SP = 64;
  logic                 mclk = 1'b0;
  logic                 nrst = 1'b0;
  sio_pkg::sio_av_req_s av_req = '0;
  sio_pkg::sio_av_rsp_s av_rsp;
  logic [9:0]           pin_in, boost, filt, logi;
  logic [9:0]           sensor = 10'h0;
  logic [1:0]           probe, tdrv;
  logic [1:0]           open_line = 2'h0;
  logic [3:0]           stuck = 4'h0;
  logic [3:0]           drv;
  logic                 inv, off;
  logic [2:0]           fb_m = 3'h0;
  logic [1:0]           fb_p = 2'h0;
  logic [15:0]          cyc_out = 16'h0;
  logic [15:0]          sci;
  logic [31:0]          q;
  int                   error_cnt = 0;
  int                   comparisons = 0;
  always #50 mclk = ~mclk;
  sio_cond #(.BOOST_CYC(BC), .SAMPLE_PER(SP)) dut_u (.mclk(mclk), .nrst(nrst),
    .av_req(av_req), .av_rsp(av_rsp), .pin_in(pin_in), .tri_probe_in(probe),
    .io_drive_en(drv), .inv_pull_en(inv), .tri_test_drive(tdrv),
    .contact_cleaning_boost(boost), .fb_a_master_bits(fb_m), .fb_a_param_bits(fb_p),
    .safe_cyclic_out(cyc_out), .safe_cyclic_in(sci), .safety_out_off(off),
    .filtered_logical_input(filt), .logical_input(logi));
  sio_field field_u (.io_drive_en(drv), .inv_pull_en(inv), .tri_test_drive(tdrv),
    .sensor(sensor), .open_line(open_line), .stuck_low(stuck), .pin_in(pin_in),
    .tri_probe_in(probe));
  // ==========================================================================
  // Shared tasks
  task automatic tally_and_finish();
    $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Holds the request until the edge that samples waitrequest low
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    av_req <= '{address: a, read: !w, write: w, writedata: d};
    k = 0;
    do begin
      @(posedge mclk);
      k++;
    end while (av_rsp.waitrequest !== 1'b0 && k < 20);
    if (k >= 20) begin
      error_cnt++;
      tally_and_finish();
    end
    q = av_rsp.readdata;
    av_req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  // Counts cycles in which a watched output is high
  task automatic cnt_hi(input int n, input int sel, output int hits);
    hits = 0;
    repeat (n) begin
      @(posedge mclk);
      hits += (sel == 0) ? int'(drv[0] === 1'b1) : (sel == 1) ? int'(tdrv != 2'h0)
            : (sel == 2) ? int'(filt[5] === 1'b1) : int'(filt[6] === 1'b1);
    end
  endtask
  // ==========================================================================
  // Scenarios
  task automatic t_regs();
    xfer(1'b0, sio_pkg::ADDR_CTRL, 0); chk("ctrl", sio_pkg::CTRL_RST, q);
    xfer(1'b0, sio_pkg::ADDR_IOCFG, 0); chk("iocfg", sio_pkg::IOCFG_RST, q);
    xfer(1'b0, 8'h3c, 0); chk("unmapped", 32'h0, q);
  endtask
  task automatic t_invert();
    cyc(8); chk("open in", 32'h0, logi[7]);
    wr(sio_pkg::ADDR_INVERT, 32'h80); cyc(8); chk("inv lo", 32'h1, logi[7]);
    chk("inv filt", 32'h1, filt[7]);
    sensor[7] <= 1'b1; cyc(8); chk("inv hi", 32'h0, logi[7]);
    sensor[7] <= 1'b0; wr(sio_pkg::ADDR_INVERT, 32'h0);
  endtask
  task automatic t_outputs();
    wr(sio_pkg::ADDR_IOCFG, 32'h155); wr(sio_pkg::ADDR_OUTCMD, 32'h15); cyc(4);
    chk("drive", 32'h5, drv); chk("pull", 32'h1, inv);
    cyc(2 * SP); chk("no trip", 32'h0, off);
    wr(sio_pkg::ADDR_OUTCMD, 32'h0a); cyc(4);
    chk("drive2", 32'ha, drv); chk("release", 32'h0, inv);
  endtask
  task automatic t_reject();
    wr(sio_pkg::ADDR_IOCFG, 32'h255); xfer(1'b0, sio_pkg::ADDR_IOCFG, 0);
    chk("reject", 32'h1, q[9]);
    wr(sio_pkg::ADDR_OUTCMD, 32'h10); cyc(4); chk("kept mode", 32'h1, inv);
  endtask
  task automatic t_trip();
    int k;
    wr(sio_pkg::ADDR_OUTCMD, 32'h1); stuck <= 4'h1;
    for (k = 0; k < 3 * SP && off !== 1'b1; k++) @(posedge mclk);
    chk("trip", 32'h1, off);
    stuck <= 4'h0; cyc(SP); chk("sticky", 32'h1, off);
    wr(sio_pkg::ADDR_CTRL, 32'h11); cyc(4); chk("cleared", 32'h0, off);
  endtask
  task automatic t_combined();
    int h;
    wr(sio_pkg::ADDR_IOCFG, 32'h2); sensor[1] <= 1'b1; cnt_hi(2 * SP, 0, h);
    chk("released", 32'h1, 32'(h > 0 && h < 2 * SP));
    chk("sensor hi", 32'h1, logi[1]);
    sensor[1] <= 1'b0; cyc(2 * SP); chk("sensor lo", 32'h0, logi[1]);
    wr(sio_pkg::ADDR_OUTCMD, 32'h0);
  endtask
  task automatic t_tristate();
    int h;
    sensor[2] <= 1'b1; open_line <= 2'b10; cyc(3 * SP);
    xfer(1'b0, sio_pkg::ADDR_STATUS, 0); chk("tri states", 32'h9, q[7:4]);
    wr(sio_pkg::ADDR_CTRL, 32'h0); cnt_hi(2 * SP, 1, h); chk("test off", 32'h0, h);
    wr(sio_pkg::ADDR_CTRL, 32'h2); cnt_hi(2 * SP, 1, h);
    chk("forced", 32'h1, 32'(h > 0));
    wr(sio_pkg::ADDR_CTRL, 32'h1); sensor[2] <= 1'b0; open_line <= 2'b00;
  endtask
  task automatic t_filter();
    int h5, h6;
    wr(sio_pkg::ADDR_FILTSEL, 32'h40); wr(sio_pkg::ADDR_RISEDLY, 32'ha);
    wr(sio_pkg::ADDR_FALLDLY, 32'ha); @(posedge mclk); sensor <= 10'h060;
    cyc(4); sensor <= 10'h0; cnt_hi(20, 2, h5); chk("bypass", 32'h1, 32'(h5 > 0));
    sensor[6] <= 1'b1; cyc(30); chk("no pulse", 32'h1, filt[6]);
    sensor[6] <= 1'b0; cyc(4); sensor[6] <= 1'b1; cnt_hi(20, 3, h6);
    chk("no gap", 32'd20, h6); sensor[6] <= 1'b0;
  endtask
  task automatic t_boost();
    sensor[0] <= 1'b1; cyc(8); chk("boost on", 32'h1, boost[0]);
    cyc(30); chk("boost held", 32'h1, boost[0]);
    cyc(30); chk("boost end", 32'h0, boost[0]); sensor[0] <= 1'b0;
  endtask
  task automatic t_fb_a();
    wr(sio_pkg::ADDR_CTRL, 32'h5); fb_m <= 3'b101; fb_p <= 2'b01; stuck <= 4'hc;
    cyc(3 * SP); chk("aux map", 32'h220, logi & 10'h260);
    chk("param out", 32'h2, drv[3:2]); chk("indicate", 32'h0, off);
    fb_m <= 3'b010; fb_p <= 2'b10; cyc(8); chk("aux map2", 32'h040, logi & 10'h260);
    chk("param out2", 32'h1, drv[3:2]); stuck <= 4'h0;
  endtask
  task automatic t_safebus();
    wr(sio_pkg::ADDR_INVERT, 32'h3ff); wr(sio_pkg::ADDR_CTRL, 32'h9);
    wr(sio_pkg::ADDR_CYCIN, 32'ha5c3); cyc_out <= 16'h3c5a; cyc(4);
    chk("cyc in", 32'ha5c3, sci);
    xfer(1'b0, sio_pkg::ADDR_CYCOUT, 0); chk("cyc out", 32'h3c5a, q);
    wr(sio_pkg::ADDR_CTRL, 32'h1); cyc(4); chk("cyc gated", 32'h0, sci);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    cyc(4);
    nrst <= 1'b1;
    t_regs(); t_invert(); t_outputs(); t_reject(); t_trip(); t_combined();
    t_tristate(); t_filter(); t_boost(); t_fb_a(); t_safebus();
    tally_and_finish();
  end
endmodule
